/* File: pkg/mode_reg_pkg.sv */
// constants for the mode register bank and its readout pages
// assumes all users refer to names as mode_reg_pkg::name
package mode_reg_pkg;
    // register select codes on {bg0, ba1, ba0}
    localparam logic [2:0] SEL_WRITE_CFG   = 3'h2;
    localparam logic [2:0] SEL_READOUT_REF = 3'h3;
    localparam logic [2:0] SEL_POWER_PRE   = 3'h4;
    localparam logic [2:0] SEL_PARITY_INV  = 3'h5;
    localparam logic [2:0] SEL_IGNORED     = 3'h7;
    localparam logic [17:0] MODE_RESET     = 18'h00000;
    // write_config_mode fields
    localparam int CRC_EN_BIT   = 12;
    localparam int DYN_TERM_LSB = 9;
    localparam int SR_TEMP_LSB  = 6;
    localparam int CWL_LSB      = 3;
    // readout_refresh_mode fields
    localparam int FORMAT_LSB   = 11;
    localparam int CRCDM_LSB    = 9;
    localparam int REFRESH_LSB  = 6;
    localparam int TEMP_RD_BIT  = 5;
    localparam int PER_DEV_BIT  = 4;
    localparam int GEAR_BIT     = 3;
    localparam int READOUT_BIT  = 2;
    localparam int PAGE_LSB     = 0;
    // power_preamble_mode fields
    localparam int HARD_REP_BIT = 13;
    localparam int WR_PRE_BIT   = 12;
    localparam int RD_PRE_BIT   = 11;
    localparam int PRE_TRN_BIT  = 10;
    localparam int SR_ABORT_BIT = 9;
    localparam int CS_LAT_LSB   = 6;
    localparam int SOFT_REP_BIT = 5;
    localparam int VREF_MON_BIT = 4;
    localparam int TCR_EN_BIT   = 3;
    localparam int TCR_EXT_BIT  = 2;
    localparam int MAX_PD_BIT   = 1;
    // parity_inversion_mode fields
    localparam int RD_INV_BIT   = 12;
    localparam int WR_INV_BIT   = 11;
    localparam int MASK_BIT     = 10;
    localparam int PERSIST_BIT  = 9;
    localparam int PARK_LSB     = 6;
    localparam int TERM_BUF_BIT = 5;
    localparam int PAR_ERR_BIT  = 4;
    localparam int CRC_ERR_BIT  = 3;
    localparam int PAR_LAT_LSB  = 0;
    // readout pages and training pattern defaults
    localparam logic [1:0] PAGE_PATTERN  = 2'h0;
    localparam logic [1:0] PAGE_LOG      = 2'h1;
    localparam logic [1:0] PAGE_SETTINGS = 2'h2;
    localparam logic [7:0] PATTERN_0_RESET = 8'h55;
    localparam logic [7:0] PATTERN_1_RESET = 8'h33;
    localparam logic [7:0] PATTERN_2_RESET = 8'h0F;
    localparam logic [7:0] PATTERN_3_RESET = 8'h00;
    localparam int READ_LATENCY = 2;
endpackage : mode_reg_pkg

/* File: verilog/pattern_store.sv */
// four-entry training pattern store with registered read data
// assumes writes and reads come from logic on the same clock
`timescale 1ns/1ps
module pattern_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    function automatic logic [WIDTH-1:0] reset_word(input int idx);
        case (idx % 4)
            0:       reset_word = WIDTH'(mode_reg_pkg::PATTERN_0_RESET);
            1:       reset_word = WIDTH'(mode_reg_pkg::PATTERN_1_RESET);
            2:       reset_word = WIDTH'(mode_reg_pkg::PATTERN_2_RESET);
            default: reset_word = WIDTH'(mode_reg_pkg::PATTERN_3_RESET);
        endcase
    endfunction : reset_word

    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                mem_reg[i] <= reset_word(i);
            end else if (wr_en && wr_addr == i) begin
                mem_reg[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule : pattern_store

/* File: verilog/mode_register_bank.sv */
// mode registers 2 to 5 of the memory device and the readout pages
// assumes command inputs are sampled on sys_clk by the command front end
`timescale 1ns/1ps
module mode_register_bank #(
    parameter logic [31:0] MAKER_DATA = 32'h00000000 // arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        mode_register_command,
    input  wire logic [2:0]  reg_select,
    input  wire logic [17:0] cmd_addr,
    input  wire logic        readout_read,
    input  wire logic        readout_write,
    input  wire logic [1:0]  readout_loc,
    input  wire logic [7:0]  readout_wdata,
    input  wire logic        parity_error_event,
    input  wire logic [17:0] err_addr,
    input  wire logic        err_act_n,
    input  wire logic [1:0]  err_bg,
    input  wire logic [1:0]  err_ba,
    input  wire logic        err_par,
    input  wire logic        crc_error_event,
    input  wire logic [4:0]  cas_latency_bits,
    input  wire logic [2:0]  nominal_term_code,
    input  wire logic [1:0]  driver_imp_code,
    input  wire logic [6:0]  vref_training,
    input  wire logic [1:0]  temp_rate,
    output logic             write_crc_en,
    output logic [2:0]       dyn_term_code,
    output logic [1:0]       self_refresh_temp_mode,
    output logic [4:0]       column_write_latency,
    output logic             readout_enable,
    output logic [1:0]       readout_page,
    output logic [1:0]       read_format,
    output logic [1:0]       crc_dm_latency_code,
    output logic [2:0]       refresh_mode,
    output logic             quarter_rate,
    output logic             per_device_en,
    output logic             temp_readout_en,
    output logic             write_preamble_2ck,
    output logic             read_preamble_2ck,
    output logic             preamble_training,
    output logic [3:0]       cs_cmd_latency,
    output logic             max_power_down,
    output logic             temp_refresh_en,
    output logic             temp_refresh_ext,
    output logic             vref_monitor_en,
    output logic             soft_row_repair,
    output logic             self_refresh_abort,
    output logic             hard_row_repair,
    output logic             read_bus_inversion,
    output logic             write_bus_inversion,
    output logic             write_data_masking,
    output logic             parity_persistent,
    output logic [2:0]       park_term_code,
    output logic             term_buffer_off,
    output logic [3:0]       address_parity_latency,
    output logic             parity_error_flag,
    output logic             crc_error_flag,
    output logic [7:0]       readout_data,
    output logic             readout_valid
);
    logic [17:0] mr2_reg, mr3_reg, mr4_reg, mr5_reg;
    logic [17:0] mr2_next, mr3_next, mr4_next, mr5_next;
    logic [17:0] log_addr_reg;
    logic [7:0]  log_ctrl_reg;
    logic [1:0]  temp_s1_reg, temp_s2_reg, temp_s3_reg, temp_status_reg;
    logic        rd_req, wr_req, rd1_reg;
    logic [1:0]  page_q_reg;
    logic [7:0]  other_q_reg, other_next, pattern_data;

    // 3-bit codes map to clock counts; all eight write latency codes are used, unused chip select and parity codes read as zero
    function automatic logic [4:0] cwl_clocks(input logic [2:0] c);
        case (c)
            3'h0:    cwl_clocks = 5'h09;
            3'h1:    cwl_clocks = 5'h0A;
            3'h2:    cwl_clocks = 5'h0B;
            3'h3:    cwl_clocks = 5'h0C;
            3'h4:    cwl_clocks = 5'h0E;
            3'h5:    cwl_clocks = 5'h10;
            3'h6:    cwl_clocks = 5'h12;
            default: cwl_clocks = 5'h14;
        endcase
    endfunction : cwl_clocks

    function automatic logic [3:0] cs_clocks(input logic [2:0] c);
        case (c)
            3'h1:    cs_clocks = 4'h3;
            3'h2:    cs_clocks = 4'h4;
            3'h3:    cs_clocks = 4'h5;
            3'h4:    cs_clocks = 4'h6;
            3'h5:    cs_clocks = 4'h8;
            default: cs_clocks = 4'h0;
        endcase
    endfunction : cs_clocks

    function automatic logic [3:0] parity_clocks(input logic [2:0] c);
        case (c)
            3'h1:    parity_clocks = 4'h4;
            3'h2:    parity_clocks = 4'h5;
            3'h3:    parity_clocks = 4'h6;
            3'h4:    parity_clocks = 4'h8;
            default: parity_clocks = 4'h0;
        endcase
    endfunction : parity_clocks

    function automatic logic hit(input logic [2:0] sel);
        hit = mode_register_command && reg_select == sel;
    endfunction : hit

    always_comb begin
        mr2_next = hit(mode_reg_pkg::SEL_WRITE_CFG) ? cmd_addr : mr2_reg;
        mr3_next = hit(mode_reg_pkg::SEL_READOUT_REF) ? cmd_addr : mr3_reg;
        mr4_next = hit(mode_reg_pkg::SEL_POWER_PRE) ? cmd_addr : mr4_reg;
        mr5_next = hit(mode_reg_pkg::SEL_PARITY_INV) ? cmd_addr : mr5_reg;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mr2_reg <= mode_reg_pkg::MODE_RESET;
            mr3_reg <= mode_reg_pkg::MODE_RESET;
            mr4_reg <= mode_reg_pkg::MODE_RESET;
            mr5_reg <= mode_reg_pkg::MODE_RESET;
        end else begin
            mr2_reg <= mr2_next;
            mr3_reg <= mr3_next;
            mr4_reg <= mr4_next;
            mr5_reg <= mr5_next;
        end
    end

    // decoded settings, registered on the same edge as the write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            write_crc_en           <= 1'b0;
            dyn_term_code          <= '0;
            self_refresh_temp_mode <= '0;
            column_write_latency   <= cwl_clocks(3'h0);
            readout_enable         <= 1'b0;
            readout_page           <= '0;
            read_format            <= '0;
            crc_dm_latency_code    <= '0;
            refresh_mode           <= '0;
            quarter_rate           <= 1'b0;
            per_device_en          <= 1'b0;
            temp_readout_en        <= 1'b0;
            write_preamble_2ck     <= 1'b0;
            read_preamble_2ck      <= 1'b0;
            preamble_training      <= 1'b0;
            cs_cmd_latency         <= '0;
            max_power_down         <= 1'b0;
            temp_refresh_en        <= 1'b0;
            temp_refresh_ext       <= 1'b0;
            vref_monitor_en        <= 1'b0;
            soft_row_repair        <= 1'b0;
            self_refresh_abort     <= 1'b0;
            hard_row_repair        <= 1'b0;
            read_bus_inversion     <= 1'b0;
            write_bus_inversion    <= 1'b0;
            write_data_masking     <= 1'b0;
            parity_persistent      <= 1'b0;
            park_term_code         <= '0;
            address_parity_latency <= '0;
        end else begin
            write_crc_en <= mr2_next[mode_reg_pkg::CRC_EN_BIT];
            dyn_term_code <= mr2_next[mode_reg_pkg::DYN_TERM_LSB +: 3];
            self_refresh_temp_mode <= mr2_next[mode_reg_pkg::SR_TEMP_LSB +: 2];
            column_write_latency <=
                cwl_clocks(mr2_next[mode_reg_pkg::CWL_LSB +: 3]);
            readout_enable <= mr3_next[mode_reg_pkg::READOUT_BIT];
            readout_page   <= mr3_next[mode_reg_pkg::PAGE_LSB +: 2];
            read_format    <= mr3_next[mode_reg_pkg::FORMAT_LSB +: 2];
            crc_dm_latency_code <= mr3_next[mode_reg_pkg::CRCDM_LSB +: 2];
            refresh_mode <= mr3_next[mode_reg_pkg::REFRESH_LSB +: 3];
            quarter_rate    <= mr3_next[mode_reg_pkg::GEAR_BIT];
            per_device_en   <= mr3_next[mode_reg_pkg::PER_DEV_BIT];
            temp_readout_en <= mr3_next[mode_reg_pkg::TEMP_RD_BIT];
            write_preamble_2ck <= mr4_next[mode_reg_pkg::WR_PRE_BIT];
            read_preamble_2ck  <= mr4_next[mode_reg_pkg::RD_PRE_BIT];
            preamble_training  <= mr4_next[mode_reg_pkg::PRE_TRN_BIT];
            cs_cmd_latency <= cs_clocks(mr4_next[mode_reg_pkg::CS_LAT_LSB +: 3]);
            max_power_down     <= mr4_next[mode_reg_pkg::MAX_PD_BIT];
            temp_refresh_en    <= mr4_next[mode_reg_pkg::TCR_EN_BIT];
            temp_refresh_ext   <= mr4_next[mode_reg_pkg::TCR_EXT_BIT];
            vref_monitor_en    <= mr4_next[mode_reg_pkg::VREF_MON_BIT];
            soft_row_repair    <= mr4_next[mode_reg_pkg::SOFT_REP_BIT];
            self_refresh_abort <= mr4_next[mode_reg_pkg::SR_ABORT_BIT];
            hard_row_repair    <= mr4_next[mode_reg_pkg::HARD_REP_BIT];
            read_bus_inversion  <= mr5_next[mode_reg_pkg::RD_INV_BIT];
            write_bus_inversion <= mr5_next[mode_reg_pkg::WR_INV_BIT];
            write_data_masking  <= mr5_next[mode_reg_pkg::MASK_BIT];
            parity_persistent <= mr5_next[mode_reg_pkg::PERSIST_BIT];
            park_term_code    <= mr5_next[mode_reg_pkg::PARK_LSB +: 3];
            address_parity_latency <=
                parity_clocks(mr5_next[mode_reg_pkg::PAR_LAT_LSB +: 3]);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            term_buffer_off <= 1'b0;
        end else begin
            term_buffer_off <= mr5_next[mode_reg_pkg::TERM_BUF_BIT]
                               && nominal_term_code != 3'h0;
        end
    end

    // set wins over a zero write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_error_flag <= 1'b0;
            crc_error_flag    <= 1'b0;
        end else begin
            if (parity_error_event) begin
                parity_error_flag <= 1'b1;
            end else if (hit(mode_reg_pkg::SEL_PARITY_INV)
                         && !cmd_addr[mode_reg_pkg::PAR_ERR_BIT]) begin
                parity_error_flag <= 1'b0;
            end
            if (crc_error_event) begin
                crc_error_flag <= 1'b1;
            end else if (hit(mode_reg_pkg::SEL_PARITY_INV)
                         && !cmd_addr[mode_reg_pkg::CRC_ERR_BIT]) begin
                crc_error_flag <= 1'b0;
            end
        end
    end

    // keep the first failing command until the flag clears
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            log_addr_reg <= '0;
            log_ctrl_reg <= '0;
        end else if (parity_error_event && !parity_error_flag) begin
            log_addr_reg <= err_addr;
            log_ctrl_reg <= {err_par, err_act_n, err_bg, err_ba,
                             err_addr[17:16]};
        end
    end

    // temperature status through a three-stage synchroniser
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_s1_reg     <= '0;
            temp_s2_reg     <= '0;
            temp_s3_reg     <= '0;
            temp_status_reg <= '0;
        end else begin
            temp_s1_reg <= temp_rate;
            temp_s2_reg <= temp_s1_reg;
            temp_s3_reg <= temp_s2_reg;
            // samples only while temp_readout_en is set and the last two stages agree; holds otherwise
            if (temp_readout_en && temp_s2_reg == temp_s3_reg) begin
                temp_status_reg <= temp_s3_reg;
            end
        end
    end

    // accesses act only while routed to the readout pages
    assign rd_req = readout_read && readout_enable;
    assign wr_req = readout_write && readout_enable
                    && readout_page == mode_reg_pkg::PAGE_PATTERN;

    pattern_store #(
        .WIDTH (8),
        .DEPTH (4)
    ) u_pattern (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr_en   (wr_req),
        .wr_addr (readout_loc),
        .wr_data (readout_wdata),
        .rd_addr (readout_loc),
        .rd_data (pattern_data)
    );

    // settings page assembled from live fields
    always_comb begin
        other_next = 8'h00;
        case (readout_page)
            mode_reg_pkg::PAGE_LOG: begin
                case (readout_loc)
                    2'h0:    other_next = log_addr_reg[7:0];
                    2'h1:    other_next = log_addr_reg[15:8];
                    2'h2:    other_next = log_ctrl_reg;
                    default: other_next = {crc_error_flag, parity_error_flag,
                                           mr5_reg[2], mr5_reg[1], mr5_reg[0],
                                           3'h0};
                endcase
            end
            mode_reg_pkg::PAGE_SETTINGS: begin
                case (readout_loc)
                    2'h0:    other_next = {mr4_reg[13], mr4_reg[5],
                                           mr2_reg[11], temp_status_reg,
                                           mr2_reg[12], mr2_reg[10:9]};
                    2'h1:    other_next = {vref_training, mr3_reg[3]};
                    2'h2:    other_next = {cas_latency_bits, mr2_reg[5:3]};
                    default: other_next = {nominal_term_code, mr5_reg[8:6],
                                           driver_imp_code};
                endcase
            end
            default: other_next = MAKER_DATA[readout_loc*8 +: 8];
        endcase
    end

    // two-stage read so the pattern store output stays registered
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd1_reg       <= 1'b0;
            page_q_reg    <= '0;
            other_q_reg   <= '0;
            readout_data  <= '0;
            readout_valid <= 1'b0;
        end else begin
            rd1_reg       <= rd_req;
            page_q_reg    <= readout_page;
            other_q_reg   <= other_next;
            readout_valid <= rd1_reg;
            if (rd1_reg) begin
                readout_data <= page_q_reg == mode_reg_pkg::PAGE_PATTERN
                                ? pattern_data : other_q_reg;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence read_issued;
        readout_read && readout_enable;
    endsequence
    sequence read_answered;
        ##2 readout_valid;
    endsequence

    ignore_code_a: assert property (
        mode_register_command && reg_select == mode_reg_pkg::SEL_IGNORED
        |=> $stable(mr2_reg) && $stable(mr3_reg) && $stable(mr4_reg)
            && $stable(mr5_reg))
        else $error("ignored select changed a register");
    crc_enable_a: assert property (
        hit(mode_reg_pkg::SEL_WRITE_CFG) |=> write_crc_en == $past(cmd_addr[12]))
        else $error("crc enable not taken");
    latency_top_a: assert property (
        hit(mode_reg_pkg::SEL_WRITE_CFG) && cmd_addr[5:3] == 3'h7
        |=> column_write_latency == 5'h14)
        else $error("write latency code 7 not 20");
    read_timing_a: assert property (
        read_issued |-> read_answered)
        else $error("readout answer not two cycles late");
    cs_latency_a: assert property (
        hit(mode_reg_pkg::SEL_POWER_PRE) && cmd_addr[8:6] == 3'h5
        |=> cs_cmd_latency == 4'h8)
        else $error("chip select latency code 5 not 8");
    parity_lat_a: assert property (
        hit(mode_reg_pkg::SEL_PARITY_INV) && cmd_addr[2:0] == 3'h4
        |=> address_parity_latency == 4'h8)
        else $error("parity latency code 4 not 8");
    set_wins_a: assert property (
        parity_error_event |=> parity_error_flag)
        else $error("parity error event lost");
    term_ignore_a: assert property (
        nominal_term_code == 3'h0 |=> !term_buffer_off)
        else $error("buffer bit honoured with termination off");
    temp_frozen_a: assert property (
        !temp_readout_en ##1 !temp_readout_en |-> $stable(temp_status_reg))
        else $error("temperature status moved while disabled");
    field_hold_a: assert property (
        !mode_register_command |=> $stable(mr3_reg) && $stable(mr5_reg))
        else $error("mode field changed without a command");
endmodule : mode_register_bank

/* File: bench/mode_cmd_model.sv */
// controller model issuing mode register commands
// assumes the bench calls issue just after a rising edge
`timescale 1ns/1ps
module mode_cmd_model (
    input  wire logic   sys_clk,
    output logic        mode_register_command,
    output logic [2:0]  reg_select,
    output logic [17:0] cmd_addr
);
    initial begin
        mode_register_command = 1'b0;
        reg_select            = 3'h0;
        cmd_addr              = 18'h00000;
    end
    task automatic issue(input logic [2:0] s, input logic [17:0] a);
        logic [17:0] keep;
        // reserved bits zero, no long write preamble, crc+mask code 4 clk
        case (s)
            3'h2: keep = 18'h01EF8;
            3'h3: keep = 18'h019FF;
            3'h4: keep = 18'h02FFE;
            default: keep = 18'h01FFF;
        endcase
        mode_register_command = 1'b1;
        reg_select            = s;
        cmd_addr              = a & keep;
        @(posedge sys_clk);
        #1;
        // released lines flip so stale values cannot look valid
        mode_register_command = 1'b0;
        reg_select            = ~reg_select;
        cmd_addr              = ~cmd_addr;
        // one idle edge so a following call never re-raises in this step
        @(posedge sys_clk);
        #1;
    endtask : issue
endmodule : mode_cmd_model

/* File: bench/test_mode_register_bank.sv */
// self-checking bench for the mode register bank
// assumes mode_cmd_model drives the command pins; one 200 MHz clock
`timescale 1ns/1ps
module test_mode_register_bank;
    logic sys_clk = 0, reset_n = 0, readout_read = 0, readout_write = 0;
    logic parity_error_event = 0, crc_error_event = 0, err_act_n = 1;
    logic err_par = 1, mode_register_command;
    logic [1:0]  readout_loc = 0, err_bg = 2, err_ba = 1;
    logic [1:0]  driver_imp_code = 1, temp_rate = 1;
    logic [7:0]  readout_wdata = 0, readout_data;
    logic [17:0] err_addr = 18'h2A5A5, cmd_addr;
    logic [4:0]  cas_latency_bits = 5'h13, column_write_latency;
    logic [2:0]  nominal_term_code = 0, reg_select, dyn_term_code;
    logic [2:0]  refresh_mode, park_term_code;
    logic [6:0]  vref_training = 7'h2A;
    logic [1:0]  self_refresh_temp_mode, readout_page, read_format;
    logic [1:0]  crc_dm_latency_code;
    logic [3:0]  cs_cmd_latency, address_parity_latency;
    logic write_crc_en, readout_enable, quarter_rate, per_device_en;
    logic temp_readout_en, write_preamble_2ck, read_preamble_2ck;
    logic preamble_training, max_power_down, temp_refresh_en;
    logic temp_refresh_ext, vref_monitor_en, soft_row_repair;
    logic self_refresh_abort, hard_row_repair, read_bus_inversion;
    logic write_bus_inversion, write_data_masking, parity_persistent;
    logic term_buffer_off, parity_error_flag, crc_error_flag, readout_valid;
    int fail_count = 0, checks_done = 0;
    // rows: {write latency, chip select latency, parity latency} by code
    logic [12:0] rows [8] = '{{5'd9, 4'd0, 4'd0}, {5'd10, 4'd3, 4'd4},
        {5'd11, 4'd4, 4'd5}, {5'd12, 4'd5, 4'd6}, {5'd14, 4'd6, 4'd8},
        {5'd16, 4'd8, 4'd0}, {5'd18, 4'd0, 4'd0}, {5'd20, 4'd0, 4'd0}};
    mode_register_bank dut (.*);
    mode_cmd_model     ctl (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic cyc;
        @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [1:0] l, input logic [7:0] e);
        readout_read = 1;
        readout_loc  = l;
        cyc;
        readout_read = 0;
        cyc;
        chk("readout_valid", 1, readout_valid);
        chk("readout_data", e, readout_data);
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        chk("cwl_reset", 9, column_write_latency);
        reset_n = 1;
        for (int i = 0; i < 8; i++) begin
            ctl.issue(3'h2, 18'(i) << 3);
            ctl.issue(3'h4, 18'(i) << 6);
            ctl.issue(3'h5, 18'(i));
            chk("cwl", 8'(rows[i][12:8]), column_write_latency);
            chk("cs_lat", 8'(rows[i][7:4]), cs_cmd_latency);
            chk("par_lat", 8'(rows[i][3:0]), address_parity_latency);
        end
        ctl.issue(3'h7, 18'h00000);
        ctl.issue(3'h6, 18'h01FFF);
        chk("ignored", 20, column_write_latency);
        ctl.issue(3'h2, 18'h01680);
        chk("crc_en", 1, write_crc_en);
        chk("dyn_term", 3, dyn_term_code);
        chk("sr_mode", 2, self_refresh_temp_mode);
        chk("par_lat_hold", 0, address_parity_latency);
        ctl.issue(3'h5, 18'h01E60);
        chk("persist_park", 8'h09, {parity_persistent, park_term_code});
        chk("inv_mask", 7, {read_bus_inversion, write_bus_inversion,
            write_data_masking});
        chk("buf_off_nom0", 0, term_buffer_off);
        nominal_term_code = 1;
        cyc;
        chk("buf_off", 1, term_buffer_off);
        parity_error_event = 1;
        crc_error_event    = 1;
        cyc;
        parity_error_event = 0;
        crc_error_event    = 0;
        cyc;
        chk("flags", 3, {crc_error_flag, parity_error_flag});
        ctl.issue(3'h3, 18'h00005);
        rd(0, 8'hA5);
        rd(2, 8'hE6);
        rd(3, 8'hC0);
        ctl.issue(3'h5, 18'h00000);
        chk("flags_clr", 0, {crc_error_flag, parity_error_flag});
        ctl.issue(3'h3, 18'h00004);
        rd(0, 8'h55);
        rd(3, 8'h00);
        readout_write = 1;
        readout_loc   = 2;
        readout_wdata = 8'hC3;
        cyc;
        readout_write = 0;
        rd(2, 8'hC3);
        ctl.issue(3'h4, 18'h02E3E);
        chk("mr4_hi", 8'h0F, {write_preamble_2ck, hard_row_repair,
            read_preamble_2ck, preamble_training, self_refresh_abort});
        chk("mr4_lo", 8'h1F, {soft_row_repair, vref_monitor_en,
            temp_refresh_en, temp_refresh_ext, max_power_down});
        ctl.issue(3'h3, 18'h0097E);
        chk("fmt", 1, read_format);
        chk("crc_dm", 0, crc_dm_latency_code);
        chk("refresh", 5, refresh_mode);
        chk("mr3_bits", 7, {quarter_rate, per_device_en, temp_readout_en});
        rd(0, 8'hCF);
        rd(3, 8'h21);
        rd(2, 8'h98);
        wrap_up;
    end
endmodule : test_mode_register_bank
